// *** design/oipd_decoder.sv ***
`timescale 1ns/1ns
`default_nettype none

// Function
// - byte 10 selects second opcode page
// - byte 11 selects third opcode page
// - taken long branch costs one more
// - indexed total is base plus postbyte extra
// - bits six and five pick X Y U S
// - zero offset adds nothing, bit4 indirect
// - bit7 clear: five-bit signed offset, one cycle
// - eight/sixteen bit offsets cost one/four
// - accumulator offsets A B one, D four
// - post increment one/two costs two/three
// - pre decrement one/two costs two/three
// - only step-two forms indirect, costing six
// - pc relative offsets cost one/five
// - extended indirect adds five cycles, two bytes
module oipd_decoder
(
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // opcode byte from the sequencer
    input wire logic opcode_valid,
    input wire logic [7:0] opcode_byte,
    // postbyte and cost figures from the sequencer
    input wire logic postbyte_valid,
    input wire logic [7:0] postbyte,
    input wire logic [5:0] base_cycles,
    input wire logic branch_taken,
    // decoded opcode
    output logic op_valid,
    output logic [7:0] op_code,
    output oipd_pkg::oipd_page_e op_page,
    output logic prefix_pending,
    // decoded postbyte
    output logic idx_valid,
    output oipd_pkg::oipd_reg_e idx_base_reg,
    output logic idx_use_pc,
    output oipd_pkg::oipd_ofs_e idx_ofs_src,
    output logic [4:0] idx_short_ofs,
    output logic [2:0] idx_step,
    output logic idx_indirect,
    output logic idx_ext_indirect,
    output logic [1:0] idx_extra_bytes,
    output logic idx_undefined,
    output logic [5:0] total_cycles
);
    // ========================================================
    // prefix tracking
    oipd_pkg::oipd_page_e page_reg, page_next;
    wire logic is_p2 = opcode_byte == oipd_pkg::SECOND_PAGE_PREFIX;
    wire logic is_p3 = opcode_byte == oipd_pkg::THIRD_PAGE_PREFIX;
    // a prefix only counts on page one; a repeated prefix byte is taken
    // as a page opcode so the stream never stalls on prefix chains
    wire logic take_prefix = opcode_valid &&
        page_reg == oipd_pkg::OIPD_PAGE_ONE && (is_p2 || is_p3);

    always_comb
    begin
        page_next = page_reg;
        if (opcode_valid)
        begin
            if (take_prefix && is_p2)
                page_next = oipd_pkg::OIPD_PAGE_TWO;
            else if (take_prefix)
                page_next = oipd_pkg::OIPD_PAGE_THREE;
            else
                page_next = oipd_pkg::OIPD_PAGE_ONE;
        end
    end

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            page_reg <= oipd_pkg::OIPD_PAGE_ONE;
            prefix_pending <= 1'b0;
            op_valid <= 1'b0;
            op_code <= 8'h00;
            op_page <= oipd_pkg::OIPD_PAGE_ONE;
        end
        else
        begin
            page_reg <= page_next;
            prefix_pending <= page_next != oipd_pkg::OIPD_PAGE_ONE;
            op_valid <= opcode_valid && !take_prefix;
            if (opcode_valid && !take_prefix)
            begin
                op_code <= opcode_byte;
                op_page <= page_reg;
            end
        end
    end

    // ========================================================
    // postbyte decode
    oipd_if pb_bus ();
    assign pb_bus.postbyte = postbyte;
    oipd_postbyte_dec u_dec
    (
        .pb(pb_bus)
    );

    // base count, extra from postbyte, one more for a taken branch
    wire logic [5:0] cyc_sum = base_cycles +
        (postbyte_valid ? {2'h0, pb_bus.extra_cycles} : 6'h00) +
        (branch_taken ? oipd_pkg::BRANCH_TAKEN_ADD : 6'h00);

    always_ff @(posedge core_clk)
    begin
        if (rst)
        begin
            idx_valid <= 1'b0;
            idx_base_reg <= oipd_pkg::OIPD_REG_X;
            idx_use_pc <= 1'b0;
            idx_ofs_src <= oipd_pkg::OIPD_OFS_NONE;
            idx_short_ofs <= 5'h00;
            idx_step <= oipd_pkg::STEP_NONE;
            idx_indirect <= 1'b0;
            idx_ext_indirect <= 1'b0;
            idx_extra_bytes <= oipd_pkg::BYTES_NONE;
            idx_undefined <= 1'b0;
            total_cycles <= 6'h00;
        end
        else
        begin
            idx_valid <= postbyte_valid;
            total_cycles <= cyc_sum;
            if (postbyte_valid)
            begin
                idx_base_reg <= pb_bus.base_reg;
                idx_use_pc <= pb_bus.use_pc;
                idx_ofs_src <= pb_bus.ofs_src;
                idx_short_ofs <= pb_bus.short_ofs;
                idx_step <= pb_bus.step;
                idx_indirect <= pb_bus.indirect;
                idx_ext_indirect <= pb_bus.ext_indirect;
                idx_extra_bytes <= pb_bus.extra_bytes;
                idx_undefined <= pb_bus.undefined;
            end
        end
    end

    // ========================================================
    // checks
    property p_page_two;
        @(posedge core_clk) disable iff (rst)
        (opcode_valid && is_p2 && page_reg == oipd_pkg::OIPD_PAGE_ONE)
        ##1 (opcode_valid && !is_p2 && !is_p3)
        |=> (op_valid && op_page == oipd_pkg::OIPD_PAGE_TWO);
    endproperty
    a_page_two: assert property (p_page_two)
        else $error("second page not applied");

    property p_page_three;
        @(posedge core_clk) disable iff (rst)
        (opcode_valid && is_p3 && page_reg == oipd_pkg::OIPD_PAGE_ONE)
        |=> (!op_valid && page_reg == oipd_pkg::OIPD_PAGE_THREE);
    endproperty
    a_page_three: assert property (p_page_three)
        else $error("third page prefix not held");

    property p_branch;
        @(posedge core_clk) disable iff (rst)
        (branch_taken && !postbyte_valid)
        |=> total_cycles == $past(base_cycles) + 6'h01;
    endproperty
    a_branch: assert property (p_branch)
        else $error("taken branch count wrong");

    property p_total;
        @(posedge core_clk) disable iff (rst)
        (postbyte_valid && !branch_taken)
        |=> total_cycles == $past(base_cycles) + {2'h0, $past(
            pb_bus.extra_cycles)};
    endproperty
    a_total: assert property (p_total)
        else $error("indexed total wrong");

    property p_five_bit;
        @(posedge core_clk) disable iff (rst)
        (postbyte_valid && !postbyte[7]) |=>
        (idx_ofs_src == oipd_pkg::OIPD_OFS_FIVE && !idx_indirect &&
         idx_extra_bytes == 2'h0);
    endproperty
    a_five_bit: assert property (p_five_bit)
        else $error("five bit form wrong");

    property p_step1_undef;
        @(posedge core_clk) disable iff (rst)
        (postbyte_valid && postbyte[7] && postbyte[4] &&
         (postbyte[3:0] == 4'h0 || postbyte[3:0] == 4'h2))
        |=> idx_undefined;
    endproperty
    a_step1_undef: assert property (p_step1_undef)
        else $error("indirect single step not flagged");

    property p_ext;
        @(posedge core_clk) disable iff (rst)
        (postbyte_valid && postbyte == 8'h9F && !branch_taken) |=>
        (idx_ext_indirect && idx_extra_bytes == 2'h2 &&
         total_cycles == $past(base_cycles) + 6'h05);
    endproperty
    a_ext: assert property (p_ext)
        else $error("extended indirect wrong");

    property p_off16;
        @(posedge core_clk) disable iff (rst)
        (postbyte_valid && postbyte[7] && !postbyte[4] &&
         postbyte[3:0] == 4'h9 && !branch_taken) |=>
        (total_cycles == $past(base_cycles) + 6'h04 &&
         idx_base_reg == oipd_pkg::oipd_reg_e'($past(postbyte[6:5])));
    endproperty
    a_off16: assert property (p_off16)
        else $error("sixteen bit offset wrong");

    c_page_two: cover property (@(posedge core_clk)
        op_valid && op_page == oipd_pkg::OIPD_PAGE_TWO);
    c_indirect: cover property (@(posedge core_clk)
        idx_valid && idx_indirect && !idx_undefined);
    c_undef: cover property (@(posedge core_clk)
        idx_valid && idx_undefined);

endmodule : oipd_decoder

`default_nettype wire

// *** include/oipd_pkg.sv ***
`default_nettype none

package oipd_pkg;

    // ========================================================
    // opcode pages
    localparam logic [7:0] SECOND_PAGE_PREFIX = 8'h10;
    localparam logic [7:0] THIRD_PAGE_PREFIX = 8'h11;

    typedef enum logic [1:0]
    {
        OIPD_PAGE_ONE = 2'h0,
        OIPD_PAGE_TWO = 2'h1,
        OIPD_PAGE_THREE = 2'h3
    } oipd_page_e;

    // ========================================================
    // postbyte fields
    localparam int PB_DIRECT_BIT = 7;
    localparam int PB_INDIRECT_BIT = 4;
    localparam int PB_REG_HI = 6;
    localparam int PB_REG_LO = 5;
    localparam logic [7:0] EXT_INDIRECT_CODE = 8'h9F;

    // low four bits of postbyte with bit 7 set
    localparam logic [3:0] LOW_INC1 = 4'h0;
    localparam logic [3:0] LOW_INC2 = 4'h1;
    localparam logic [3:0] LOW_DEC1 = 4'h2;
    localparam logic [3:0] LOW_DEC2 = 4'h3;
    localparam logic [3:0] LOW_ZERO = 4'h4;
    localparam logic [3:0] LOW_ACC_B = 4'h5;
    localparam logic [3:0] LOW_ACC_A = 4'h6;
    localparam logic [3:0] LOW_OFF8 = 4'h8;
    localparam logic [3:0] LOW_OFF16 = 4'h9;
    localparam logic [3:0] LOW_ACC_D = 4'hB;
    localparam logic [3:0] LOW_PC_REL8 = 4'hC;
    localparam logic [3:0] LOW_PC_REL16 = 4'hD;
    localparam logic [3:0] LOW_EXT = 4'hF;

    // base register select
    typedef enum logic [1:0]
    {
        OIPD_REG_X = 2'h0,
        OIPD_REG_Y = 2'h1,
        OIPD_REG_U = 2'h2,
        OIPD_REG_S = 2'h3
    } oipd_reg_e;

    // offset source
    typedef enum logic [2:0]
    {
        OIPD_OFS_NONE = 3'h0,
        OIPD_OFS_FIVE = 3'h1,
        OIPD_OFS_BYTE = 3'h2,
        OIPD_OFS_WORD = 3'h3,
        OIPD_OFS_ACC_A = 3'h4,
        OIPD_OFS_ACC_B = 3'h5,
        OIPD_OFS_ACC_D = 3'h6
    } oipd_ofs_e;

    // auto step: signed adjustment to the base register
    localparam logic [2:0] STEP_NONE = 3'h0;
    localparam logic [2:0] STEP_POST_INC1 = 3'h1;
    localparam logic [2:0] STEP_POST_INC2 = 3'h2;
    localparam logic [2:0] STEP_PRE_DEC1 = 3'h3;
    localparam logic [2:0] STEP_PRE_DEC2 = 3'h4;

    // ========================================================
    // cycle and byte costs
    localparam logic [3:0] CYC_ZERO = 4'h0;
    localparam logic [3:0] CYC_FIVE_BIT = 4'h1;
    localparam logic [3:0] CYC_OFF8 = 4'h1;
    localparam logic [3:0] CYC_OFF16 = 4'h4;
    localparam logic [3:0] CYC_ACC_AB = 4'h1;
    localparam logic [3:0] CYC_ACC_D = 4'h4;
    localparam logic [3:0] CYC_STEP1 = 4'h2;
    localparam logic [3:0] CYC_STEP2 = 4'h3;
    localparam logic [3:0] CYC_STEP2_IND = 4'h6;
    localparam logic [3:0] CYC_PC_REL8 = 4'h1;
    localparam logic [3:0] CYC_PC_REL16 = 4'h5;
    localparam logic [3:0] CYC_EXT_IND = 4'h5;
    localparam logic [3:0] CYC_IND_ADD = 4'h3;
    localparam logic [1:0] BYTES_NONE = 2'h0;
    localparam logic [1:0] BYTES_ONE = 2'h1;
    localparam logic [1:0] BYTES_TWO = 2'h2;
    localparam logic [5:0] BRANCH_TAKEN_ADD = 6'h01;

endpackage : oipd_pkg

`default_nettype wire

// *** include/oipd_if.sv ***
`timescale 1ns/1ns
`default_nettype none

// carries one decoded postbyte from the decoder leaf to the top
interface oipd_if;
    logic [7:0] postbyte;
    oipd_pkg::oipd_reg_e base_reg;
    logic use_pc;
    oipd_pkg::oipd_ofs_e ofs_src;
    logic [4:0] short_ofs;
    logic [2:0] step;
    logic indirect;
    logic ext_indirect;
    logic [3:0] extra_cycles;
    logic [1:0] extra_bytes;
    logic undefined;

    modport dec
    (
        input postbyte,
        output base_reg, use_pc, ofs_src, short_ofs, step, indirect,
        output ext_indirect, extra_cycles, extra_bytes, undefined
    );
    modport use_side
    (
        output postbyte,
        input base_reg, use_pc, ofs_src, short_ofs, step, indirect,
        input ext_indirect, extra_cycles, extra_bytes, undefined
    );
endinterface : oipd_if

`default_nettype wire

// *** design/oipd_postbyte_dec.sv ***
`timescale 1ns/1ns
`default_nettype none

module oipd_postbyte_dec
(
    oipd_if.dec pb
);
    wire logic [7:0] p = pb.postbyte;
    wire logic direct_form = p[oipd_pkg::PB_DIRECT_BIT];
    wire logic ind = p[oipd_pkg::PB_INDIRECT_BIT];
    wire logic [3:0] low = p[3:0];
    wire logic is_ext = (p == oipd_pkg::EXT_INDIRECT_CODE);
    wire logic is_pc_rel = direct_form &&
        (low == oipd_pkg::LOW_PC_REL8 || low == oipd_pkg::LOW_PC_REL16);

    // ========================================================
    // field decode
    // register field is meaningless for relative and extended forms
    assign pb.base_reg = oipd_pkg::oipd_reg_e'(p[6:5]);
    assign pb.use_pc = is_pc_rel;
    assign pb.ext_indirect = is_ext;
    assign pb.short_ofs = p[4:0];
    // five-bit form has no indirect variant
    assign pb.indirect = direct_form && ind;

    logic [2:0] ofs;
    logic [2:0] stp;
    logic [3:0] cyc;
    logic [1:0] byt;
    logic undef;

    always_comb
    begin
        ofs = oipd_pkg::OIPD_OFS_NONE;
        stp = oipd_pkg::STEP_NONE;
        cyc = oipd_pkg::CYC_ZERO;
        byt = oipd_pkg::BYTES_NONE;
        undef = 1'b0;
        if (!direct_form)
        begin
            ofs = oipd_pkg::OIPD_OFS_FIVE;
            cyc = oipd_pkg::CYC_FIVE_BIT;
        end
        else
        begin
            unique case (low)
                oipd_pkg::LOW_ZERO: cyc = oipd_pkg::CYC_ZERO;
                oipd_pkg::LOW_OFF8:
                begin
                    ofs = oipd_pkg::OIPD_OFS_BYTE;
                    cyc = oipd_pkg::CYC_OFF8;
                    byt = oipd_pkg::BYTES_ONE;
                end
                oipd_pkg::LOW_OFF16:
                begin
                    ofs = oipd_pkg::OIPD_OFS_WORD;
                    cyc = oipd_pkg::CYC_OFF16;
                    byt = oipd_pkg::BYTES_TWO;
                end
                oipd_pkg::LOW_ACC_A:
                begin
                    ofs = oipd_pkg::OIPD_OFS_ACC_A;
                    cyc = oipd_pkg::CYC_ACC_AB;
                end
                oipd_pkg::LOW_ACC_B:
                begin
                    ofs = oipd_pkg::OIPD_OFS_ACC_B;
                    cyc = oipd_pkg::CYC_ACC_AB;
                end
                oipd_pkg::LOW_ACC_D:
                begin
                    ofs = oipd_pkg::OIPD_OFS_ACC_D;
                    cyc = oipd_pkg::CYC_ACC_D;
                end
                oipd_pkg::LOW_INC1:
                begin
                    stp = oipd_pkg::STEP_POST_INC1;
                    cyc = oipd_pkg::CYC_STEP1;
                    undef = ind;
                end
                oipd_pkg::LOW_INC2:
                begin
                    stp = oipd_pkg::STEP_POST_INC2;
                    cyc = oipd_pkg::CYC_STEP2;
                end
                oipd_pkg::LOW_DEC1:
                begin
                    stp = oipd_pkg::STEP_PRE_DEC1;
                    cyc = oipd_pkg::CYC_STEP1;
                    undef = ind;
                end
                oipd_pkg::LOW_DEC2:
                begin
                    stp = oipd_pkg::STEP_PRE_DEC2;
                    cyc = oipd_pkg::CYC_STEP2;
                end
                oipd_pkg::LOW_PC_REL8:
                begin
                    ofs = oipd_pkg::OIPD_OFS_BYTE;
                    cyc = oipd_pkg::CYC_PC_REL8;
                    byt = oipd_pkg::BYTES_ONE;
                end
                oipd_pkg::LOW_PC_REL16:
                begin
                    ofs = oipd_pkg::OIPD_OFS_WORD;
                    cyc = oipd_pkg::CYC_PC_REL16;
                    byt = oipd_pkg::BYTES_TWO;
                end
                oipd_pkg::LOW_EXT:
                begin
                    ofs = oipd_pkg::OIPD_OFS_WORD;
                    cyc = oipd_pkg::CYC_EXT_IND;
                    byt = oipd_pkg::BYTES_TWO;
                    undef = !is_ext;
                end
                default: undef = 1'b1;
            endcase
            // indirection adds a pointer fetch; step-by-two is its own cost
            if (ind && !undef)
            begin
                if (stp == oipd_pkg::STEP_POST_INC2 ||
                    stp == oipd_pkg::STEP_PRE_DEC2)
                    cyc = oipd_pkg::CYC_STEP2_IND;
                else if (!is_ext)
                    cyc = cyc + oipd_pkg::CYC_IND_ADD;
            end
        end
    end

    assign pb.ofs_src = oipd_pkg::oipd_ofs_e'(ofs);
    assign pb.step = stp;
    assign pb.extra_cycles = cyc;
    assign pb.extra_bytes = byt;
    assign pb.undefined = undef;

endmodule : oipd_postbyte_dec

`default_nettype wire

// *** tb/oipd_seq_model.sv ***
`timescale 1ns/1ns
`default_nettype none

// ============================================================
// sequencer stand-in: presents opcode bytes, postbytes, costs
module oipd_seq_model
(
    // opcode stream
    output var logic opcode_valid,
    output var logic [7:0] opcode_byte,
    // postbyte and cost figures
    output var logic postbyte_valid,
    output var logic [7:0] postbyte,
    output var logic [5:0] base_cycles,
    output var logic branch_taken
);
    initial
    begin
        opcode_valid = 1'b0;
        opcode_byte = 8'h00;
        postbyte_valid = 1'b0;
        postbyte = 8'h00;
        base_cycles = 6'h00;
        branch_taken = 1'b0;
    end

    // called just after a rising edge; an unqualified byte is inverted
    // so that a stale value never passes for a fresh one
    task put_op(input logic v, input logic [7:0] b);
        opcode_valid <= v;
        opcode_byte <= v ? b : ~opcode_byte;
    endtask : put_op

    task put_pb(input logic v, input logic [7:0] b);
        postbyte_valid <= v;
        postbyte <= v ? b : ~postbyte;
    endtask : put_pb

    task put_cost(input logic [5:0] base, input logic taken);
        base_cycles <= base;
        branch_taken <= taken;
    endtask : put_cost
endmodule : oipd_seq_model

`default_nettype wire

// *** tb/opcode_and_index_postbyte_decoder_tb_top.sv ***
`timescale 1ns/1ns
`default_nettype none

module opcode_and_index_postbyte_decoder_tb_top;
    // ========================================================
    // nibble and bit tables indexed by postbyte low four bits
    localparam logic [63:0] CYC_PLAIN = 64'h5051_4041_0110_3232;
    localparam logic [63:0] CYC_IND = 64'h5084_7074_0443_6060;
    localparam logic [63:0] BYTES = 64'h2021_0021_0000_0000;
    localparam logic [63:0] OFS = 64'h3032_6032_0450_0000;
    localparam logic [63:0] STEPS = 64'h0000_0000_0000_4321;
    localparam logic [15:0] HOLE_PLAIN = 16'hC480;
    localparam logic [15:0] HOLE_IND = 16'h4485;

    logic core_clk, rst;
    wire logic opcode_valid, postbyte_valid, branch_taken;
    wire logic [7:0] opcode_byte, postbyte;
    wire logic [5:0] base_cycles;
    logic op_valid, prefix_pending, idx_valid, idx_use_pc;
    logic idx_indirect, idx_ext_indirect, idx_undefined;
    logic [7:0] op_code;
    oipd_pkg::oipd_page_e op_page;
    oipd_pkg::oipd_reg_e idx_base_reg;
    oipd_pkg::oipd_ofs_e idx_ofs_src;
    logic [4:0] idx_short_ofs;
    logic [2:0] idx_step;
    logic [1:0] idx_extra_bytes;
    logic [5:0] total_cycles;
    int bad_count = 0;
    int n_compared = 0;

    initial core_clk = 1'b0;
    always #25 core_clk = ~core_clk;
    initial rst = 1'b1;

    oipd_seq_model oipd_seq_model_inst (.opcode_valid, .opcode_byte,
        .postbyte_valid, .postbyte, .base_cycles, .branch_taken);

    oipd_decoder oipd_decoder_inst (.core_clk, .rst, .opcode_valid,
        .opcode_byte, .postbyte_valid, .postbyte, .base_cycles,
        .branch_taken, .op_valid, .op_code, .op_page, .prefix_pending,
        .idx_valid, .idx_base_reg, .idx_use_pc, .idx_ofs_src,
        .idx_short_ofs, .idx_step, .idx_indirect, .idx_ext_indirect,
        .idx_extra_bytes, .idx_undefined, .total_cycles);

    task automatic chk(input string name, input logic [7:0] seen,
        input logic [7:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            bad_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop;
        $display("compared %0d mismatches %0d", n_compared, bad_count);
        if (bad_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : report_and_stop

    // ========================================================
    // scenarios
    task automatic test_reset;
        repeat (2) @(posedge core_clk);
        #1;
        chk("op_valid", {7'h0, op_valid}, 8'h00);
        chk("op_page", {6'h0, op_page}, 8'h00);
        chk("prefix_pending", {7'h0, prefix_pending}, 8'h00);
        chk("idx_valid", {7'h0, idx_valid}, 8'h00);
        chk("total_cycles", {2'h0, total_cycles}, 8'h00);
        @(posedge core_clk);
        rst <= 1'b0;
        $display("reset test done");
    endtask : test_reset

    task automatic pair(input logic [7:0] pre, input logic [7:0] op,
        input logic [1:0] page);
        oipd_seq_model_inst.put_op(1'b1, pre);
        @(posedge core_clk);
        oipd_seq_model_inst.put_op(1'b1, op);
        #1;
        chk("prefix_pending", {7'h0, prefix_pending},
            8'h01);
        chk("op_valid", {7'h0, op_valid}, 8'h00);
        @(posedge core_clk);
        oipd_seq_model_inst.put_op(1'b0, 8'h00);
        #1;
        chk("op_valid", {7'h0, op_valid}, 8'h01);
        chk("op_code", op_code, op);
        chk("op_page", {6'h0, op_page}, {6'h0, page});
        chk("prefix_pending", {7'h0, prefix_pending},
            8'h00);
        @(posedge core_clk);
    endtask : pair

    task automatic test_pages;
        pair(oipd_pkg::SECOND_PAGE_PREFIX, 8'hCE, 2'h1);
        pair(oipd_pkg::THIRD_PAGE_PREFIX, 8'h8C, 2'h3);
        // a second prefix while paged is an ordinary page-two opcode
        pair(8'h10, 8'h10, 2'h1);
        oipd_seq_model_inst.put_op(1'b1, 8'h86);
        @(posedge core_clk);
        oipd_seq_model_inst.put_op(1'b0, 8'h00);
        #1;
        chk("op_valid", {7'h0, op_valid}, 8'h01);
        chk("op_page", {6'h0, op_page}, 8'h00);
        chk("op_code", op_code, 8'h86);
        @(posedge core_clk);
        $display("page test done");
    endtask : test_pages

    task automatic test_mid_reset;
        oipd_seq_model_inst.put_op(1'b1, 8'h11);
        @(posedge core_clk);
        oipd_seq_model_inst.put_op(1'b0, 8'h00);
        rst <= 1'b1;
        @(posedge core_clk);
        #1;
        chk("prefix_pending", {7'h0, prefix_pending}, 8'h00);
        @(posedge core_clk);
        rst <= 1'b0;
        oipd_seq_model_inst.put_op(1'b1, 8'hCE);
        @(posedge core_clk);
        oipd_seq_model_inst.put_op(1'b0, 8'h00);
        #1;
        chk("op_page", {6'h0, op_page}, 8'h00);
        @(posedge core_clk);
        $display("mid reset test done");
    endtask : test_mid_reset

    task automatic test_branch;
        oipd_seq_model_inst.put_cost(6'h05, 1'b0);
        @(posedge core_clk);
        oipd_seq_model_inst.put_cost(6'h05, 1'b1);
        #1;
        chk("total_cycles", {2'h0, total_cycles}, 8'h05);
        @(posedge core_clk);
        oipd_seq_model_inst.put_cost(6'h04, 1'b0);
        #1;
        chk("total_cycles", {2'h0, total_cycles}, 8'h06);
        @(posedge core_clk);
        $display("branch test done");
    endtask : test_branch

    task automatic check_pb(input logic [7:0] pb);
        logic [3:0] lo;
        logic ind;
        logic und;
        logic [3:0] cyc;
        lo = pb[3:0];
        ind = pb[7] & pb[4];
        und = pb[7] & (ind ? (HOLE_IND[lo] | (lo == 4'hF && pb != 8'h9F))
            : HOLE_PLAIN[lo]);
        cyc = !pb[7] ? 4'h1 : ind ? CYC_IND[lo * 4 +: 4]
            : CYC_PLAIN[lo * 4 +: 4];
        chk("idx_valid", {7'h0, idx_valid}, 8'h01);
        chk("idx_base_reg", {6'h0, idx_base_reg}, {6'h0, pb[6:5]});
        chk("idx_short_ofs", {3'h0, idx_short_ofs},
            {3'h0, pb[4:0]});
        chk("idx_indirect", {7'h0, idx_indirect}, {7'h0, ind});
        chk("idx_ext_indirect", {7'h0, idx_ext_indirect},
            {7'h0, pb == 8'h9F});
        chk("idx_undefined", {7'h0, idx_undefined}, {7'h0, und});
        if (!und)
        begin
            chk("idx_use_pc", {7'h0, idx_use_pc},
                {7'h0, pb[7] & lo[3] & lo[2] & !lo[1]});
            chk("idx_step", {5'h0, idx_step},
                pb[7] ? {4'h0, STEPS[lo * 4 +: 4]} : 8'h00);
            chk("idx_extra_bytes", {6'h0, idx_extra_bytes},
                pb[7] ? {4'h0, BYTES[lo * 4 +: 4]} : 8'h00);
            chk("total_cycles", {2'h0, total_cycles},
                8'h04 + {4'h0, cyc});
            chk("idx_ofs_src", {5'h0, idx_ofs_src},
                pb[7] ? {4'h0, OFS[lo * 4 +: 4]} : 8'h01);
        end
    endtask : check_pb

    // every postbyte value, back to back
    task automatic test_postbytes;
        oipd_seq_model_inst.put_cost(6'h04, 1'b0);
        for (int i = 0; i <= 256; i++)
        begin
            oipd_seq_model_inst.put_pb(i < 256, i[7:0]);
            if (i > 0)
            begin
                #1;
                check_pb(8'(i - 1));
            end
            @(posedge core_clk);
        end
        #1;
        chk("idx_valid", {7'h0, idx_valid}, 8'h00);
        chk("idx_base_reg", {6'h0, idx_base_reg}, 8'h03);
        chk("total_cycles", {2'h0, total_cycles}, 8'h04);
        $display("postbyte test done");
    endtask : test_postbytes

    initial
    begin
        repeat (5000) @(posedge core_clk);
        bad_count++;
        $display("[ERR] run limit expected finish seen hang");
        report_and_stop();
    end

    initial
    begin
        test_reset();
        test_pages();
        test_mid_reset();
        test_branch();
        test_postbytes();
        report_and_stop();
    end
endmodule : opcode_and_index_postbyte_decoder_tb_top

`default_nettype wire
